/* File: msc_pkg.sv */
package msc_pkg;
    // Register addresses
    localparam logic [15:0] MSC_ADDR_GAIN = 16'hE60F;
    localparam logic [15:0] MSC_ADDR_MAIN_CFG = 16'hE618;
    localparam logic [15:0] MSC_ADDR_THIRD_CFG = 16'hEA00;
    localparam logic [15:0] MSC_ADDR_COMP_MODE = 16'hE60E;
    localparam logic [15:0] MSC_ADDR_RUN = 16'hE228;
    localparam logic [15:0] MSC_ADDR_LAST_ACCESS = 16'hE9FE;
    localparam logic [15:0] MSC_ADDR_DIE_REV = 16'hE707;
    localparam logic [15:0] MSC_ADDR_PROTECT = 16'hE7E3;
    localparam logic [15:0] MSC_ADDR_COMMIT = 16'hE7EF;
    localparam logic [15:0] MSC_ADDR_KEY = 16'hE7FE;
    localparam logic [15:0] MSC_ADDR_INTERNAL = 16'hE90C;
    localparam logic [15:0] MSC_HARM_LO = 16'hE880;
    localparam logic [15:0] MSC_HARM_HI = 16'hE89F;
    // Key and command values
    localparam logic [7:0] MSC_KEY_VALUE = 8'hAD;
    localparam logic [7:0] MSC_PROTECT_VALUE = 8'h80;
    localparam logic [7:0] MSC_COMMIT_VALUE = 8'h00;
    // Field positions
    localparam int MSC_CUR_GAIN_LSB = 0;
    localparam int MSC_VOLT_GAIN_LSB = 3;
    localparam int MSC_NEUT_GAIN_LSB = 6;
    localparam int MSC_PHASE_INT_BIT = 0;
    localparam int MSC_NEUT_INT_BIT = 3;
    localparam int MSC_HPF_BIT = 0;
    localparam int MSC_FREQ_BIT = 14;
    localparam int MSC_RUN_BIT = 0;
    localparam int MSC_HPF_PATHS = 7;
    localparam int MSC_HPF_PHASE_C_VOLT = 6;
    // Values after reset
    localparam logic [15:0] MSC_RESET_WORD = 16'h0000;
    localparam logic [8:0] MSC_RESET_GAIN = 9'h000;
    localparam logic [7:0] MSC_RESET_BYTE = 8'h00;

    typedef struct packed {
        logic valid;
        logic write;
        logic from_spi;
        logic [15:0] addr;
        logic [15:0] wdata;
    } msc_req_type;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } msc_rsp_type;

    typedef enum logic [1:0] {
        MSC_IDLE,
        MSC_ARMED,
        MSC_STAGED
    } msc_unlock_type;
endpackage

/* File: msc_setup_regs.sv */
// Notes on behaviour
// R1 - Three 3-bit gain fields, low nine bits
// R2 - Integrator enables: main bit 0, third bit 3
// R3 - Computation mode bit 14 selects 60 Hz
// R4 - Host writes key then 0x80 to protect
// R5 - Host configures first, then sets run
// R6 - Read-only 8-bit die revision, writes ignored
// R7 - Every read records its address, except affected SPI harmonic reads (R8)
// R8 - Affected SPI harmonic reads record address plus one
// R9 - Host subtracts one for affected harmonic reads
// R10 - Host writes key, internal value, then commit
// R11 - Internal-setting writes must be back to back
// R12 - Captured internal setting reads back as written
// R13 - Filter bit low bypasses all high-pass filters except the phase C voltage filter on the affected revision
// R14 - Affected revision keeps phase C voltage filter on
// R15 - Key unlocks only the very next access, so an intervening read cancels it
`timescale 1ns/10ps
`default_nettype none
module msc_setup_regs
    import msc_pkg::*;
#(
    parameter logic [7:0] DIE_REVISION = 8'h5A, // Arbitrary value
    parameter logic [7:0] AFFECTED_REVISION = 8'h5A // Arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire msc_req_type req,
    output msc_rsp_type rsp,
    output logic [2:0] current_gain_select,
    output logic [2:0] voltage_gain_select,
    output logic [2:0] neutral_gain_select,
    output logic phase_integrator_on,
    output logic neutral_integrator_on,
    output logic line_freq_select,
    output logic [MSC_HPF_PATHS-1:0] highpass_filter_on,
    output logic ram_protect_on,
    output logic [15:0] internal_setting,
    output logic dsp_run
);
    logic [8:0] gain;
    logic [15:0] main_cfg;
    logic [15:0] third_configuration;
    logic [15:0] computation_mode_reg;
    logic [7:0] ram_protect_control;
    logic [15:0] staged_setting;
    logic [15:0] last_access;
    msc_unlock_type unlock_state;
    logic affected;
    logic wr;
    logic rd;
    logic key_wr;
    logic harm_spi;
    logic [15:0] next_rdata;

    assign affected = (DIE_REVISION == AFFECTED_REVISION);
    assign wr = req.valid && req.write;
    assign rd = req.valid && !req.write;
    assign key_wr = wr && req.addr == MSC_ADDR_KEY && req.wdata[7:0] == MSC_KEY_VALUE;
    assign harm_spi = req.from_spi && affected && req.addr >= MSC_HARM_LO
        && req.addr <= MSC_HARM_HI;

    // Setup registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain <= MSC_RESET_GAIN;
            main_cfg <= MSC_RESET_WORD;
            third_configuration <= MSC_RESET_WORD;
            computation_mode_reg <= MSC_RESET_WORD;
        end else if (wr) begin
            if (req.addr == MSC_ADDR_GAIN) begin
                gain <= req.wdata[8:0]; // [R1]
            end
            if (req.addr == MSC_ADDR_MAIN_CFG) begin
                main_cfg <= req.wdata; // [R2]
            end
            if (req.addr == MSC_ADDR_THIRD_CFG) begin
                third_configuration <= req.wdata; // [R2] [R13]
            end
            if (req.addr == MSC_ADDR_COMP_MODE) begin
                computation_mode_reg <= req.wdata; // [R3]
            end
        end
    end

    assign current_gain_select = gain[MSC_CUR_GAIN_LSB +: 3]; // [R1]
    assign voltage_gain_select = gain[MSC_VOLT_GAIN_LSB +: 3]; // [R1]
    assign neutral_gain_select = gain[MSC_NEUT_GAIN_LSB +: 3]; // [R1]
    assign phase_integrator_on = main_cfg[MSC_PHASE_INT_BIT]; // [R2]
    assign neutral_integrator_on = third_configuration[MSC_NEUT_INT_BIT]; // [R2]
    assign line_freq_select = computation_mode_reg[MSC_FREQ_BIT]; // [R3]

    // Run control
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dsp_run <= 1'b0;
        end else if (wr && req.addr == MSC_ADDR_RUN) begin
            dsp_run <= req.wdata[MSC_RUN_BIT]; // [R5]
        end
    end

    // High-pass filter enables per path
    genvar gi;
    generate
        for (gi = 0; gi < MSC_HPF_PATHS; gi++) begin : g_hpf
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    highpass_filter_on[gi] <= 1'b0;
                end else if (gi == MSC_HPF_PHASE_C_VOLT && affected) begin
                    highpass_filter_on[gi] <= 1'b1; // [R14]
                end else begin
                    highpass_filter_on[gi] <= third_configuration[MSC_HPF_BIT]; // [R13]
                end
            end
        end
    endgenerate

    // Key unlock sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            unlock_state <= MSC_IDLE;
        end else if (req.valid) begin
            if (key_wr) begin
                unlock_state <= MSC_ARMED; // [R15]
            end else begin
                case (unlock_state)
                    MSC_ARMED: begin
                        if (wr && req.addr == MSC_ADDR_INTERNAL) begin
                            unlock_state <= MSC_STAGED; // [R11]
                        end else begin
                            unlock_state <= MSC_IDLE; // [R15]
                        end
                    end
                    default: begin
                        unlock_state <= MSC_IDLE; // [R11]
                    end
                endcase
            end
        end
    end

    // Protection and internal setting
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_protect_control <= MSC_RESET_BYTE;
            ram_protect_on <= 1'b0;
            staged_setting <= MSC_RESET_WORD;
            internal_setting <= MSC_RESET_WORD;
        end else if (wr) begin
            if (unlock_state == MSC_ARMED && req.addr == MSC_ADDR_PROTECT
                && req.wdata[7:0] == MSC_PROTECT_VALUE) begin
                ram_protect_control <= req.wdata[7:0]; // [R4]
                ram_protect_on <= 1'b1; // [R4]
            end
            if (unlock_state == MSC_ARMED && req.addr == MSC_ADDR_INTERNAL) begin
                staged_setting <= req.wdata; // [R10]
            end
            if (unlock_state == MSC_STAGED && req.addr == MSC_ADDR_COMMIT
                && req.wdata[7:0] == MSC_COMMIT_VALUE) begin
                internal_setting <= staged_setting; // [R12]
            end
        end
    end

    // Last accessed address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_access <= MSC_RESET_WORD;
        end else if (rd) begin
            last_access <= harm_spi ? req.addr + 16'h0001 : req.addr; // [R7] [R8]
        end
    end

    // Read data
    always_comb begin
        case (req.addr)
            MSC_ADDR_GAIN: next_rdata = {7'h00, gain};
            MSC_ADDR_MAIN_CFG: next_rdata = main_cfg;
            MSC_ADDR_THIRD_CFG: next_rdata = third_configuration;
            MSC_ADDR_COMP_MODE: next_rdata = computation_mode_reg;
            MSC_ADDR_RUN: next_rdata = {15'h0000, dsp_run};
            MSC_ADDR_LAST_ACCESS: next_rdata = last_access;
            MSC_ADDR_DIE_REV: next_rdata = {8'h00, DIE_REVISION}; // [R6]
            MSC_ADDR_PROTECT: next_rdata = {8'h00, ram_protect_control};
            MSC_ADDR_INTERNAL: next_rdata = internal_setting; // [R12]
            default: next_rdata = MSC_RESET_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp <= '0;
        end else begin
            rsp.valid <= rd;
            rsp.rdata <= rd ? next_rdata : MSC_RESET_WORD;
        end
    end

    sequence s_key;
        req.valid && req.write && req.addr == MSC_ADDR_KEY && req.wdata[7:0] == MSC_KEY_VALUE;
    endsequence

    sequence s_gap;
        !req.valid;
    endsequence

    sequence s_protect_wr;
        req.valid && req.write && req.addr == MSC_ADDR_PROTECT
            && req.wdata[7:0] == MSC_PROTECT_VALUE;
    endsequence

    sequence s_internal_wr;
        req.valid && req.write && req.addr == MSC_ADDR_INTERNAL;
    endsequence

    sequence s_commit_wr;
        req.valid && req.write && req.addr == MSC_ADDR_COMMIT
            && req.wdata[7:0] == MSC_COMMIT_VALUE;
    endsequence

    property p_gain_fields;
        @(posedge clk) disable iff (!arst_n)
        (wr && req.addr == MSC_ADDR_GAIN) |=> current_gain_select == $past(req.wdata[2:0])
            && voltage_gain_select == $past(req.wdata[5:3])
            && neutral_gain_select == $past(req.wdata[8:6]);
    endproperty
    a_gain_fields: assert property (p_gain_fields) else $error("gain field wrong"); // [R1]

    property p_integrators;
        @(posedge clk) disable iff (!arst_n)
        (wr && req.addr == MSC_ADDR_THIRD_CFG) |=> neutral_integrator_on == $past(req.wdata[3]);
    endproperty
    a_integrators: assert property (p_integrators) else $error("integrator wrong"); // [R2]

    property p_phase_int;
        @(posedge clk) disable iff (!arst_n)
        (wr && req.addr == MSC_ADDR_MAIN_CFG) |=> phase_integrator_on == $past(req.wdata[0]);
    endproperty
    a_phase_int: assert property (p_phase_int) else $error("phase integrator wrong"); // [R2]

    property p_line_freq;
        @(posedge clk) disable iff (!arst_n)
        (wr && req.addr == MSC_ADDR_COMP_MODE) |=> line_freq_select == $past(req.wdata[14]);
    endproperty
    a_line_freq: assert property (p_line_freq) else $error("line frequency wrong"); // [R3]

    property p_protect;
        @(posedge clk) disable iff (!arst_n)
        s_key ##1 s_gap ##1 s_protect_wr |=> ram_protect_on;
    endproperty
    a_protect: assert property (p_protect) else $error("protection not set"); // [R4]

    property p_run;
        @(posedge clk) disable iff (!arst_n)
        (wr && req.addr == MSC_ADDR_RUN && req.wdata[0]) |=> dsp_run;
    endproperty
    a_run: assert property (p_run) else $error("run not set"); // [R5]

    property p_revision;
        @(posedge clk) disable iff (!arst_n)
        (rd && req.addr == MSC_ADDR_DIE_REV) |=> rsp.valid && rsp.rdata[7:0] == DIE_REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("revision read wrong"); // [R6]

    property p_last_plain;
        @(posedge clk) disable iff (!arst_n)
        (rd && !harm_spi) |=> last_access == $past(req.addr);
    endproperty
    a_last_plain: assert property (p_last_plain) else $error("last address wrong"); // [R7]

    property p_last_harm;
        @(posedge clk) disable iff (!arst_n)
        (rd && harm_spi) |=> last_access == $past(req.addr) + 16'h0001;
    endproperty
    a_last_harm: assert property (p_last_harm) else $error("harmonic address wrong"); // [R8]

    property p_internal;
        @(posedge clk) disable iff (!arst_n)
        s_key ##1 s_gap ##1 s_internal_wr ##1 s_gap ##1 s_commit_wr
            |=> internal_setting == $past(req.wdata, 3);
    endproperty
    a_internal: assert property (p_internal) else $error("setting not captured"); // [R12]

    property p_commit_refused;
        @(posedge clk) disable iff (!arst_n)
        (wr && req.addr == MSC_ADDR_COMMIT && unlock_state != MSC_STAGED)
            |=> $stable(internal_setting);
    endproperty
    a_commit_refused: assert property (p_commit_refused) else $error("stray commit"); // [R11]

    property p_hpf;
        @(posedge clk) disable iff (!arst_n)
        !third_configuration[MSC_HPF_BIT] |=> highpass_filter_on[5:0] == 6'h00
            && highpass_filter_on[6] == affected;
    endproperty
    a_hpf: assert property (p_hpf) else $error("filter enable wrong"); // [R13] [R14]

    property p_cancel;
        @(posedge clk) disable iff (!arst_n)
        s_key ##1 s_gap ##1 (rd && req.addr != MSC_ADDR_KEY) ##1 s_gap
            ##1 (s_protect_wr and !ram_protect_on) |=> !ram_protect_on;
    endproperty
    a_cancel: assert property (p_cancel) else $error("unlock not cancelled"); // [R15]
endmodule
`default_nettype wire

/* File: msc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_host_model
    import msc_pkg::*;
(
    input wire logic clk,
    output msc_req_type req,
    input wire msc_rsp_type rsp
);
    initial req = '0;
    // One access held for one taking edge, released lines then inverted
    task automatic access(input logic w, input logic s, input logic [15:0] a,
            input logic [15:0] d, output logic [15:0] rd);
        @(posedge clk);
        req <= '{valid: 1'b1, write: w, from_spi: s, addr: a, wdata: d};
        @(posedge clk);
        req <= '{valid: 1'b0, write: ~w, from_spi: ~s, addr: ~a, wdata: ~d};
        #1;
        rd = (rsp.valid === 1'b1) ? rsp.rdata : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

/* File: msc_setup_regs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_setup_regs_tb_top
    import msc_pkg::*;
;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary revision code
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    msc_req_type req;
    msc_rsp_type rsp;
    logic [2:0] cur_g, volt_g, neut_g;
    logic ph_int, ne_int, freq, prot, run;
    logic [6:0] hpf;
    logic [15:0] iset;
    int fails = 0;
    int checks = 0;
    always #4 clk = ~clk;
    msc_setup_regs #(.DIE_REVISION(REV), .AFFECTED_REVISION(REV)) uut (
        .clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp),
        .current_gain_select(cur_g), .voltage_gain_select(volt_g),
        .neutral_gain_select(neut_g), .phase_integrator_on(ph_int),
        .neutral_integrator_on(ne_int), .line_freq_select(freq),
        .highpass_filter_on(hpf), .ram_protect_on(prot),
        .internal_setting(iset), .dsp_run(run)
    );
    msc_host_model host (.clk(clk), .req(req), .rsp(rsp));
    task automatic tally_and_finish;
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] x;
        host.access(1'b1, 1'b1, a, d, x);
    endtask
    task automatic rdc(input logic s, input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] x;
        host.access(1'b0, s, a, 16'h0000, x);
        cmp(x, exp);
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    initial begin
        #100000;
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        step;
        cmp({9'h000, hpf}, 16'h0040);
        wr(MSC_ADDR_GAIN, 16'h01D1);
        step;
        cmp({7'h00, neut_g, volt_g, cur_g}, 16'h01D1);
        wr(MSC_ADDR_MAIN_CFG, 16'h0001);
        wr(MSC_ADDR_THIRD_CFG, 16'h0008);
        wr(MSC_ADDR_COMP_MODE, 16'h4000);
        step;
        cmp({13'h0000, freq, ne_int, ph_int}, 16'h0007);
        cmp({9'h000, hpf}, 16'h0040);
        wr(MSC_ADDR_THIRD_CFG, 16'h0009);
        step;
        cmp({9'h000, hpf}, 16'h007F);
        wr(MSC_ADDR_DIE_REV, 16'h00FF);
        rdc(1'b1, MSC_ADDR_DIE_REV, {8'h00, REV});
        rdc(1'b0, MSC_ADDR_LAST_ACCESS, MSC_ADDR_DIE_REV);
        rdc(1'b1, 16'hE885, 16'h0000);
        rdc(1'b1, MSC_ADDR_LAST_ACCESS, 16'hE886);
        rdc(1'b0, 16'hE885, 16'h0000);
        rdc(1'b0, MSC_ADDR_LAST_ACCESS, 16'hE885);
        rdc(1'b1, 16'hE8A0, 16'h0000);
        rdc(1'b1, MSC_ADDR_LAST_ACCESS, 16'hE8A0);
        wr(MSC_ADDR_KEY, 16'h00AD);
        rdc(1'b0, MSC_ADDR_GAIN, 16'h01D1);
        wr(MSC_ADDR_PROTECT, 16'h0080);
        wr(MSC_ADDR_KEY, 16'h00AD);
        wr(MSC_ADDR_PROTECT, 16'h007F);
        step;
        cmp({15'h0000, prot}, 16'h0000);
        wr(MSC_ADDR_KEY, 16'h00AD);
        wr(MSC_ADDR_PROTECT, 16'h0080);
        step;
        cmp({15'h0000, prot}, 16'h0001);
        wr(MSC_ADDR_KEY, 16'h00AD);
        wr(MSC_ADDR_INTERNAL, 16'h03BD);
        rdc(1'b0, MSC_ADDR_GAIN, 16'h01D1);
        wr(MSC_ADDR_COMMIT, 16'h0000);
        step;
        cmp(iset, 16'h0000);
        wr(MSC_ADDR_KEY, 16'h00AD);
        wr(MSC_ADDR_INTERNAL, 16'h03BD);
        wr(MSC_ADDR_COMMIT, 16'h0000);
        step;
        cmp(iset, 16'h03BD);
        rdc(1'b1, MSC_ADDR_INTERNAL, 16'h03BD);
        cmp({15'h0000, run}, 16'h0000);
        wr(MSC_ADDR_RUN, 16'h0001);
        step;
        cmp({15'h0000, run}, 16'h0001);
        tally_and_finish;
    end
endmodule
`default_nettype wire
